// ==== inc/clock_reset_consts.svh ====
// constants for the clock and reset management block
// assumes inclusion by bare name from the modules
`ifndef CLOCK_RESET_CONSTS_SVH
`define CLOCK_RESET_CONSTS_SVH

// register offsets
`define MAIN_CLOCK_CONTROL_OFS 8'h38
`define OSCILLATOR_TRIM_OFS    8'h39
`define INTEGRITY_STATUS_OFS   8'h3a
`define IRQ_STATUS_OFS         8'h3b
`define IRQ_MASK_OFS           8'h3c
// field positions
`define SLOW_SELECT_BIT        0
`define CLOCK_OUT_ENABLE_BIT   1
`define PLL_LOCK_BIT           3
// reset values and control write mask
`define MAIN_CLOCK_CONTROL_RST 8'h00
`define OSCILLATOR_TRIM_RST    8'hff
`define CONTROL_WRITE_MASK     8'h03
// timing
`define SLOW_DIVIDE            6'd32
`define DELAY_CYCLES           9'd256
`define FETCH_CYCLES           2'd2
`define ACTIVE_CYCLES          4'd4
`define PLL_STARTUP_CYCLES     12'd1000
// vector
`define RESET_VECTOR_ADDR      16'hfffe

`endif

// ==== inc/clock_reset_pkg.sv ====
// types for the clock and reset management block
// assumes the consts header on the include path
package clock_reset_pkg;
    typedef enum logic [2:0] {
        seq_idle,
        seq_active,
        seq_delay,
        seq_startup,
        seq_fetch
    } seq_state_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        fetch;
        logic [15:0] addr;
    } vector_fetch_t;
endpackage : clock_reset_pkg

// ==== rtl/slow_divider.sv ====
// divide-by-32 enable generator for slow mode
// assumes a free running clock and synchronous reset
`timescale 1ns/1ps
`include "clock_reset_consts.svh"
module slow_divider
    import clock_reset_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic slow_select,
    output logic      cpu_enable
);
    typedef struct packed {
        logic [4:0] count;
    } div_state_t;

    div_state_t state;
    div_state_t next_state;

    // count 0..31, enable once per wrap in slow mode
    always_comb begin
        next_state = state;
        next_state.count = state.count + 5'd1;
        if (!slow_select)
            next_state.count = 5'd0;
    end

    always_ff @(posedge clock) begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign cpu_enable = !slow_select || (state.count == 5'd31);

    slow_rate_a: assert property (@(posedge clock) disable iff (rst)
        slow_select && cpu_enable |=> (!cpu_enable || !slow_select))
        else $error("slow enable fired twice in a row");
endmodule : slow_divider

// ==== rtl/reset_sequencer.sv ====
// three-phase reset sequencer with optional pll startup wait
// assumes cpu_enable pulses at the cpu clock rate
`timescale 1ns/1ps
`include "clock_reset_consts.svh"
module reset_sequencer
    import clock_reset_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    rst,
    input  wire logic    cpu_enable,
    input  wire logic    request,
    input  wire logic    pll_enable,
    output logic         reset_pin_low,
    output logic         cpu_reset,
    output logic         pll_clock_gate,
    output vector_fetch_t vec
);
    typedef struct packed {
        seq_state_t  phase;
        logic [11:0] count;
        logic        pll_ok;
    } seq_t;

    seq_t state;
    seq_t next_state;

    // phase progression; a new request restarts from active
    always_comb begin
        next_state = state;
        case (state.phase)
            seq_idle: ;
            seq_active: begin
                next_state.count = state.count + 12'd1;
                if (state.count == 12'(`ACTIVE_CYCLES) - 12'd1) begin
                    next_state.phase = seq_delay;
                    next_state.count = '0;
                end
            end
            seq_delay: if (cpu_enable) begin
                next_state.count = state.count + 12'd1;
                if (state.count == 12'(`DELAY_CYCLES) - 12'd1) begin
                    next_state.count = '0;
                    next_state.phase = pll_enable ? seq_startup : seq_fetch;
                end
            end
            seq_startup: begin
                next_state.count = state.count + 12'd1;
                if (state.count == `PLL_STARTUP_CYCLES - 12'd1) begin
                    next_state.count = '0;
                    next_state.phase = seq_fetch;
                    next_state.pll_ok = 1'b1;
                end
            end
            seq_fetch: begin
                next_state.count = state.count + 12'd1;
                if (state.count == 12'(`FETCH_CYCLES) - 12'd1)
                    next_state.phase = seq_idle;
            end
            default: next_state.phase = seq_idle;
        endcase
        if (request) begin
            next_state.phase = seq_active;
            next_state.count = '0;
            next_state.pll_ok = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state.phase <= seq_active;
            state.count <= '0;
            state.pll_ok <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // outputs
    assign reset_pin_low = (state.phase == seq_active) || (state.phase == seq_delay);
    assign cpu_reset = state.phase != seq_idle;
    assign pll_clock_gate = state.pll_ok || !pll_enable;
    assign vec.fetch = state.phase == seq_fetch;
    assign vec.addr = `RESET_VECTOR_ADDR | {15'd0, state.count[0]};

    sequence fetch_two_s;
        vec.fetch [*2] ##1 !vec.fetch;
    endsequence
    fetch_len_a: assert property (@(posedge clock) disable iff (rst || request)
        $rose(vec.fetch) |-> fetch_two_s)
        else $error("vector fetch not two cycles");
    fetch_addr_a: assert property (@(posedge clock) disable iff (rst)
        $rose(vec.fetch) |-> vec.addr == 16'hfffe)
        else $error("vector fetch starts off fffe");
    pin_low_a: assert property (@(posedge clock) disable iff (rst)
        state.phase == seq_delay |-> reset_pin_low)
        else $error("reset pin released in delay");
    restart_a: assert property (@(posedge clock) disable iff (rst)
        request |=> state.phase == seq_active && state.count == 12'd0)
        else $error("request did not restart sequence");
    phase_order_a: assert property (@(posedge clock) disable iff (rst || request)
        $rose(vec.fetch) |-> $past(state.phase) inside {seq_delay, seq_startup})
        else $error("fetch entered out of order");
endmodule : reset_sequencer

// ==== rtl/clock_reset_management.sv ====
// clock and reset management: control registers, trim, lock status, reset sequencing
// assumes a plain register port with read data one cycle after the strobe
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "clock_reset_consts.svh"
module clock_reset_management
    import clock_reset_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        write,
    input  wire logic        read,
    output logic      [7:0]  rdata,
    input  wire logic        reset_pin_in,
    input  wire logic        watchdog_reset,
    input  wire logic        illegal_opcode,
    input  wire logic        pll_locked,
    input  wire logic        pll_enable,
    output logic             clock_out,
    output logic             clock_out_oe,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    output logic             cpu_enable,
    output logic             cpu_reset,
    output logic             pll_clock_gate,
    output logic      [7:0]  trim_value,
    output vector_fetch_t    vec,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] trim;
        logic [7:0] rdata;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic       lock_seen;
    } top_t;

    top_t     state;
    top_t     next_state;
    reg_req_t req;
    logic     seq_request;
    logic     pin_low;
    logic [2:0] events;
    logic [7:0] status_view;

    assign req = '{write: write, read: read, addr: addr, wdata: wdata};

    // all reset sources funnel into one request
    assign seq_request = !reset_pin_in && !pin_low || watchdog_reset || illegal_opcode;

    // events: lock gained, lock lost, reset request
    assign events = {seq_request, state.lock_seen && !pll_locked, !state.lock_seen && pll_locked};

    // status with reserved bits at zero
    assign status_view = 8'(pll_locked) << `PLL_LOCK_BIT;

    ////////////////////////////////////////////////////////////////////////
    // register file and interrupt flags
    always_comb begin
        next_state = state;
        next_state.lock_seen = pll_locked;
        next_state.rdata = 8'h00;
        if (req.write) begin
            case (req.addr)
                `MAIN_CLOCK_CONTROL_OFS: next_state.control = req.wdata & `CONTROL_WRITE_MASK;
                `OSCILLATOR_TRIM_OFS:    next_state.trim = req.wdata;
                `IRQ_STATUS_OFS:         next_state.irq_status = state.irq_status & ~req.wdata[2:0];
                `IRQ_MASK_OFS:           next_state.irq_mask = req.wdata[2:0];
                default: ;
            endcase
        end
        // set wins over write-one-to-clear
        next_state.irq_status = next_state.irq_status | events;
        if (req.read) begin
            case (req.addr)
                `MAIN_CLOCK_CONTROL_OFS: next_state.rdata = state.control;
                `OSCILLATOR_TRIM_OFS:    next_state.rdata = state.trim;
                `INTEGRITY_STATUS_OFS:   next_state.rdata = status_view;
                `IRQ_STATUS_OFS:         next_state.rdata = {5'd0, state.irq_status};
                `IRQ_MASK_OFS:           next_state.rdata = {5'd0, state.irq_mask};
                default:                 next_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state.control <= `MAIN_CLOCK_CONTROL_RST;
            state.trim <= `OSCILLATOR_TRIM_RST;
            state.rdata <= 8'h00;
            state.irq_status <= 3'd0;
            state.irq_mask <= 3'd0;
            state.lock_seen <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock selection and outputs
    slow_divider u_div (
        .clock       (clock),
        .rst         (rst),
        .slow_select (state.control[`SLOW_SELECT_BIT]),
        .cpu_enable  (cpu_enable)
    );

    reset_sequencer u_seq (
        .clock          (clock),
        .rst            (rst),
        .cpu_enable     (cpu_enable),
        .request        (seq_request),
        .pll_enable     (pll_enable),
        .reset_pin_low  (pin_low),
        .cpu_reset      (cpu_reset),
        .pll_clock_gate (pll_clock_gate),
        .vec            (vec)
    );

    // clock out pin gated by control bit
    assign clock_out = clock & state.control[`CLOCK_OUT_ENABLE_BIT];
    assign clock_out_oe = state.control[`CLOCK_OUT_ENABLE_BIT];
    // reset pin is open drain, pulled low during the active and delay phases
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = pin_low;
    assign trim_value = state.trim;
    assign rdata = state.rdata;
    assign irq = |(state.irq_status & state.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // checks
    ctrl_reserved_a: assert property (@(posedge clock) disable iff (rst)
        read && addr == `MAIN_CLOCK_CONTROL_OFS |=> rdata[7:2] == 6'd0)
        else $error("control reserved bits read nonzero");
    lock_flag_a: assert property (@(posedge clock) disable iff (rst)
        read && addr == `INTEGRITY_STATUS_OFS |=> rdata[3] == $past(pll_locked))
        else $error("lock flag does not follow pll");
    trim_write_a: assert property (@(posedge clock) disable iff (rst)
        write && addr == `OSCILLATOR_TRIM_OFS |=> trim_value == $past(wdata))
        else $error("trim write lost");
    clk_out_a: assert property (@(posedge clock) disable iff (rst)
        clock_out_oe == state.control[1] && (clock_out_oe || !clock_out))
        else $error("clock out drive mismatch");
    src_pin_a: assert property (@(posedge clock) disable iff (rst)
        watchdog_reset || illegal_opcode |=> reset_pin_oe)
        else $error("reset source did not pull pin");
endmodule : clock_reset_management

// ==== verif/reset_partner.sv ====
// partner model: reset pin wiring with pull-up, external reset driver, pll lock source
// assumes the bench moves ext_hold and lock_req right after a rising clock edge
`timescale 1ns/1ps
module reset_partner (
    input  wire logic clock,
    input  wire logic reset_pin_out,
    input  wire logic reset_pin_oe,
    input  wire logic ext_hold,
    input  wire logic lock_req,
    output logic      reset_pin_in,
    output logic      pll_locked
);
    logic [2:0] lock_pipe;
    ////////////////////////////////////////////////////////////////
    // pin level: pull-up, pulled low by either party
    assign reset_pin_in = (reset_pin_oe ? reset_pin_out : 1'b1) & ~ext_hold;
    // lock settles a few cycles after the request, like a real loop
    always_ff @(posedge clock) begin
        lock_pipe <= {lock_pipe[1:0], lock_req};
    end
    assign pll_locked = lock_pipe[2];
endmodule : reset_partner

// ==== verif/test_clock_reset_management.sv ====
// bench for the clock and reset management block
// assumes the partner model in reset_partner.sv and the design package
`timescale 1ns/1ps
module test_clock_reset_management;
    import clock_reset_pkg::*;
    logic          clock, rst, write, read, watchdog_reset, illegal_opcode;
    logic          pll_enable, ext_hold, lock_req, reset_pin_in, pll_locked, rd_flag;
    logic [7:0]    addr, wdata, rdata, trim_value, ctl, trim;
    logic          clock_out, clock_out_oe, reset_pin_out, reset_pin_oe;
    logic          cpu_enable, cpu_reset, pll_clock_gate, irq;
    vector_fetch_t vec;
    logic [15:0]   exp_q[$], vec_q[$], n;
    int            failures, checks_done, seed;

    clock_reset_management dut_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
        .write(write), .read(read), .rdata(rdata), .reset_pin_in(reset_pin_in),
        .watchdog_reset(watchdog_reset), .illegal_opcode(illegal_opcode),
        .pll_locked(pll_locked), .pll_enable(pll_enable), .clock_out(clock_out),
        .clock_out_oe(clock_out_oe), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .cpu_enable(cpu_enable), .cpu_reset(cpu_reset), .pll_clock_gate(pll_clock_gate),
        .trim_value(trim_value), .vec(vec), .irq(irq));
    reset_partner partner_u (.clock(clock), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .ext_hold(ext_hold), .lock_req(lock_req),
        .reset_pin_in(reset_pin_in), .pll_locked(pll_locked));

    ////////////////////////////////////////////////////////////////
    // clock generation
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // hang guard
    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    // register bus cycles, one strobe cycle each
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clock);
        write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({8'h00, e});
        @(posedge clock);
        addr <= a;
        read <= 1'b1;
        @(posedge clock);
        read <= 1'b0;
    endtask : rd
    // raise one reset source and leave it set: 0 watchdog, 1 illegal opcode, 2 external pin
    task automatic trigger(input int k);
        @(posedge clock);
        case (k)
            0: watchdog_reset <= 1'b1;
            1: illegal_opcode <= 1'b1;
            default: ext_hold <= 1'b1;
        endcase
    endtask : trigger
    // measure pin-driven span, pll startup span and fetch span of one sequence
    task automatic run_seq(input logic pll, input logic [15:0] exp_oe);
        logic [15:0] s, f;
        n = 16'h0000;
        s = 16'h0000;
        f = 16'h0000;
        vec_q.push_back(16'hfffe);
        vec_q.push_back(16'hffff);
        repeat (3000) begin
            @(posedge clock);
            watchdog_reset <= 1'b0;
            illegal_opcode <= 1'b0;
            ext_hold       <= 1'b0;
            if (reset_pin_oe === 1'b1) n = n + 16'h1;
            else if (cpu_reset === 1'b1 && vec.fetch !== 1'b1 && n > 0) s = s + 16'h1;
            if (vec.fetch === 1'b1) f = f + 16'h1;
            if (n > 0 && cpu_reset === 1'b0) break;
        end
        check("pin_low_span", exp_oe, n);
        check("startup_span", pll ? 16'd1000 : 16'd0, s);
        check("fetch_span", 16'd2, f);
    endtask : run_seq

    ////////////////////////////////////////////////////////////////
    // result monitor: read data and vector addresses against the notes
    always @(posedge clock) begin
        if (rd_flag === 1'b1) check("rdata", exp_q.pop_front(), {8'h00, rdata});
        rd_flag <= read;
        if (vec.fetch === 1'b1) check("vec_addr", vec_q.pop_front(), vec.addr);
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst, addr, wdata, write, read, watchdog_reset, illegal_opcode} = {1'b1, 20'h0};
        {pll_enable, ext_hold, lock_req, rd_flag, failures, checks_done} = '0;
        seed = 35414;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        vec_q.push_back(16'hfffe);
        vec_q.push_back(16'hffff);
        rd(8'h38, 8'h00);
        rd(8'h39, 8'hff);
        rd(8'h3a, 8'h00);
        rd(8'h3f, 8'h00);
        wr(8'h39, 8'h80);
        rd(8'h39, 8'h80);
        for (int i = 0; i < 400 && cpu_reset !== 1'b0; i++) @(posedge clock);
        // random control and trim values
        for (int i = 0; i < 4; i++) begin
            ctl  = 8'($random(seed)) & 8'h03;
            trim = 8'($random(seed));
            wr(8'h38, ctl);
            wr(8'h39, trim);
            rd(8'h38, ctl);
            rd(8'h39, trim);
            @(posedge clock);
            #5;
            check("trim_value", {8'h00, trim}, {8'h00, trim_value});
            check("clock_out_oe", 16'(ctl[1]), 16'(clock_out_oe));
            check("clock_out", 16'(ctl[1]), 16'(clock_out));
        end
        // reserved, read-only and unmapped places
        wr(8'h38, 8'hff);
        rd(8'h38, 8'h03);
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'h00);
        wr(8'h3f, 8'h55);
        rd(8'h3f, 8'h00);
        // slow then normal cpu rate
        for (int m = 1; m >= 0; m--) begin
            wr(8'h38, 8'(m));
            repeat (40) @(negedge clock);
            n = 16'h0000;
            repeat (64) begin
                @(negedge clock);
                n = n + 16'(cpu_enable);
            end
            check("cpu_enable_count", m ? 16'd2 : 16'd64, n);
        end
        // every reset source, then a restart in the active phase after a held watchdog request
        for (int k = 0; k < 3; k++) begin
            trigger(k);
            run_seq(0, 16'd260);
        end
        trigger(0);
        repeat (100) @(posedge clock);
        watchdog_reset <= 1'b0;
        trigger(1);
        run_seq(0, 16'd261);
        pll_enable <= 1'b1;
        trigger(0);
        run_seq(1, 16'd260);
        check("pll_clock_gate", 16'h1, 16'(pll_clock_gate));
        pll_enable <= 1'b0;
        // lock flag and interrupt: raise, mask, unmask, clear
        wr(8'h3b, 8'hff);
        wr(8'h3c, 8'h01);
        lock_req <= 1'b1;
        repeat (8) @(posedge clock);
        check("irq", 16'h1, 16'(irq));
        rd(8'h3a, 8'h08);
        rd(8'h3b, 8'h01);
        wr(8'h3c, 8'h00);
        repeat (3) @(posedge clock);
        check("irq", 16'h0, 16'(irq));
        wr(8'h3c, 8'h01);
        repeat (3) @(posedge clock);
        check("irq", 16'h1, 16'(irq));
        wr(8'h3b, 8'h01);
        repeat (3) @(posedge clock);
        check("irq", 16'h0, 16'(irq));
        lock_req <= 1'b0;
        repeat (8) @(posedge clock);
        rd(8'h3a, 8'h00);
        rd(8'h3b, 8'h02);
        repeat (4) @(posedge clock);
        print_verdict();
    end
endmodule : test_clock_reset_management
